// [hw/gpr_pkg.sv]
// Constants shared by the port logic and its register front end
package gpr_pkg;
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 5;
    localparam int PIN_COUNT = 40;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [4:0][IDX_W-1:0] LEVEL_IDX = {10'h012, 10'h00C, 10'h009, 10'h006, 10'h003};
    localparam logic [4:0][IDX_W-1:0] DIR_IDX = {10'h013, 10'h00D, 10'h00A, 10'h007, 10'h004};
    localparam logic [4:0][IDX_W-1:0] LATCH_IDX = {10'h014, 10'h00E, 10'h00B, 10'h008, 10'h005};
    localparam logic [IDX_W-1:0] DRIVE_IDX = 10'h0E0;
    localparam logic [IDX_W-1:0] ROUTE1_IDX = 10'h0ED;
    localparam logic [IDX_W-1:0] ROUTE0_IDX = 10'h0EE;

    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam int DRIVE_W = 6;
    localparam int ROUTE0_W = 7;
    localparam int ROUTE1_W = 3;

    // Routing bit positions
    localparam int R0_RXD = 0;
    localparam int R0_TXD = 1;
    localparam int R0_SS = 2;
    localparam int R0_T0A = 3;
    localparam int R0_T0B = 4;
    localparam int R0_T1A = 5;
    localparam int R0_T1B = 6;
    localparam int R0_UNLOCK = 7;
    localparam int R1_T2A = 0;
    localparam int R1_T2B = 1;
    localparam int R1_T3A = 2;

    // Unlock window in system cycles
    localparam int UNLOCK_CYCLES = 6;
    localparam int UNLOCK_W = 3;

    // Peripheral signal slots
    localparam int PF_T0A = 0;
    localparam int PF_T0B = 1;
    localparam int PF_T1A = 2;
    localparam int PF_T1B = 3;
    localparam int PF_T2A = 4;
    localparam int PF_T2B = 5;
    localparam int PF_T3A = 6;
    localparam int PF_SS = 7;
    localparam int PF_TXD = 8;
    localparam int PF_COUNT = 9;

    // Pin positions, port B at bit 0
    localparam int PIN_B1 = 1;
    localparam int PIN_B2 = 2;
    localparam int PIN_B3 = 3;
    localparam int PIN_C0 = 8;
    localparam int PIN_D0 = 16;
    localparam int PIN_D1 = 17;
    localparam int PIN_D3 = 19;
    localparam int PIN_D5 = 21;
    localparam int PIN_D6 = 22;
    localparam int PIN_E4 = 28;
    localparam int PIN_F1 = 33;
    localparam int PIN_F3 = 35;
    localparam int PIN_F4 = 36;
    localparam int PIN_F5 = 37;
    localparam int PIN_F6 = 38;
    localparam int PIN_F7 = 39;
endpackage

// [hw/gpr_port.sv]
// One eight-bit port: output latch, direction, synchronised level
`timescale 1ns/1ps
module gpr_port #(
    parameter int WIDTH = gpr_pkg::PORT_W
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_latch,
    input wire logic wr_dir,
    input wire logic wr_toggle,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] alt_en,
    input wire logic [WIDTH-1:0] alt_val,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] latch,
    output logic [WIDTH-1:0] dir,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pullup_en
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] next_latch;
    logic [WIDTH-1:0] next_dir;

    always_comb
    begin
        next_latch = latch;
        next_dir = dir;
        if (wr_latch)
        begin
            next_latch = wdata;
        end
        else if (wr_toggle)
        begin
            next_latch = latch ^ wdata;
        end
        if (wr_dir)
        begin
            next_dir = wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            latch <= '0;
            dir <= '0;
            sync1 <= '0;
            level <= '0;
        end
        else
        begin
            latch <= next_latch;
            dir <= next_dir;
            sync1 <= pin_in;
            level <= sync1;
        end
    end

    // Peripheral override only replaces the value; direction stays with software
    assign pin_oe = dir;
    assign pin_out = dir & ((alt_en & alt_val) | (~alt_en & latch));
    assign pullup_en = ~dir & latch;

    a_dir_oe: assert property (@(posedge clk) disable iff (!reset_n)
        $past(wr_dir) |-> pin_oe == $past(wdata))
        else $error("direction write not seen on output enable");
    a_pullup_in: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_latch && !wr_dir) |=> pullup_en == (~dir & $past(wdata)))
        else $error("pull-up does not follow latch on inputs");
    a_drive_level: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_latch && !wr_dir && alt_en == '0) |=> ##0 (alt_en != '0 || pin_out == (dir & $past(wdata))))
        else $error("output pin does not follow latch");
    a_toggle_latch: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_toggle && !wr_latch) |=> latch == ($past(latch) ^ $past(wdata)))
        else $error("level write did not toggle latch");
    a_level_sync: assert property (@(posedge clk) disable iff (!reset_n)
        reset_n |-> ##2 level == $past(pin_in, 2))
        else $error("level not two cycles behind pin");
endmodule // gpr_port

// [hw/gpr_top.sv]
// GPIO ports B to F with drive strength and pin routing over APB
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module gpr_top
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [gpr_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpr_pkg::DATA_W-1:0] pwdata,
    output logic [gpr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [gpr_pkg::PIN_COUNT-1:0] pin_in,
    output logic [gpr_pkg::PIN_COUNT-1:0] pin_out,
    output logic [gpr_pkg::PIN_COUNT-1:0] pin_oe,
    output logic [gpr_pkg::PIN_COUNT-1:0] pullup_en,
    output logic [gpr_pkg::DRIVE_W-1:0] high_drive,
    input wire logic [gpr_pkg::PF_COUNT-1:0] periph_out,
    input wire logic [gpr_pkg::PF_COUNT-1:0] periph_en,
    input wire logic timer0_out_a_extra_select,
    output logic serial_rxd,
    output logic timer3_alt_out,
    output logic timer3_alt_out_en
);
    localparam int W = gpr_pkg::PORT_W;
    localparam int NP = gpr_pkg::NUM_PORTS;

    logic [gpr_pkg::PIN_COUNT-1:0] latch_all;
    logic [gpr_pkg::PIN_COUNT-1:0] dir_all;
    logic [gpr_pkg::PIN_COUNT-1:0] level_all;
    logic [gpr_pkg::PIN_COUNT-1:0] alt_en;
    logic [gpr_pkg::PIN_COUNT-1:0] alt_val;
    logic [NP-1:0] wr_latch;
    logic [NP-1:0] wr_dir;
    logic [NP-1:0] wr_toggle;

    logic [gpr_pkg::ROUTE0_W-1:0] pin_routing_0;
    logic [gpr_pkg::ROUTE1_W-1:0] pin_routing_1;
    logic [gpr_pkg::DRIVE_W-1:0] drive_strength_select;
    logic [gpr_pkg::UNLOCK_W-1:0] unlock_cnt;
    logic [gpr_pkg::DATA_W-1:0] rdata;
    logic hit;

    logic [gpr_pkg::ROUTE0_W-1:0] next_pin_routing_0;
    logic [gpr_pkg::ROUTE1_W-1:0] next_pin_routing_1;
    logic [gpr_pkg::DRIVE_W-1:0] next_drive_strength_select;
    logic [gpr_pkg::UNLOCK_W-1:0] next_unlock_cnt;
    logic [gpr_pkg::DATA_W-1:0] next_rdata;
    logic next_hit;

    logic [gpr_pkg::IDX_W-1:0] idx;
    logic aligned;
    logic setup;
    logic wr;
    logic routing_write_unlock;
    logic t0a_sel;
    logic t0a_both;

    assign idx = paddr[gpr_pkg::ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign routing_write_unlock = (unlock_cnt != '0);

    // Zero wait states: read data is captured in the setup cycle
    assign pready = psel & penable;
    assign pslverr = pready & ~hit;
    assign prdata = rdata;

    // Per-port write strobes
    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            wr_latch[p] = wr & aligned & (idx == gpr_pkg::LATCH_IDX[p]);
            wr_dir[p] = wr & aligned & (idx == gpr_pkg::DIR_IDX[p]);
            wr_toggle[p] = wr & aligned & (idx == gpr_pkg::LEVEL_IDX[p]);
        end
    end

    // Register read decode and shared control registers
    always_comb
    begin
        next_rdata = '0;
        next_hit = 1'b0;
        next_pin_routing_0 = pin_routing_0;
        next_pin_routing_1 = pin_routing_1;
        next_drive_strength_select = drive_strength_select;
        next_unlock_cnt = routing_write_unlock ? unlock_cnt - 1'b1 : unlock_cnt;
        if (setup && aligned)
        begin
            for (int p = 0; p < NP; p++)
            begin
                if (idx == gpr_pkg::LEVEL_IDX[p])
                begin
                    next_rdata = {24'h000000, level_all[p*W +: W]};
                    next_hit = 1'b1;
                end
                if (idx == gpr_pkg::DIR_IDX[p])
                begin
                    next_rdata = {24'h000000, dir_all[p*W +: W]};
                    next_hit = 1'b1;
                end
                if (idx == gpr_pkg::LATCH_IDX[p])
                begin
                    next_rdata = {24'h000000, latch_all[p*W +: W]};
                    next_hit = 1'b1;
                end
            end
            if (idx == gpr_pkg::DRIVE_IDX)
            begin
                next_rdata = {26'h0, drive_strength_select};
                next_hit = 1'b1;
            end
            if (idx == gpr_pkg::ROUTE0_IDX)
            begin
                next_rdata = {24'h000000, routing_write_unlock, pin_routing_0};
                next_hit = 1'b1;
            end
            if (idx == gpr_pkg::ROUTE1_IDX)
            begin
                next_rdata = {29'h0, pin_routing_1};
                next_hit = 1'b1;
            end
        end
        else if (psel && penable)
        begin
            next_rdata = rdata;
            next_hit = hit;
        end
        if (wr && aligned && idx == gpr_pkg::DRIVE_IDX)
        begin
            next_drive_strength_select = pwdata[gpr_pkg::DRIVE_W-1:0];
        end
        if (wr && aligned && idx == gpr_pkg::ROUTE0_IDX)
        begin
            if (routing_write_unlock)
            begin
                next_pin_routing_0 = pwdata[gpr_pkg::ROUTE0_W-1:0];
            end
            else if (pwdata[gpr_pkg::R0_UNLOCK])
            begin
                // Arming write stores nothing else; the value needs a second write
                next_unlock_cnt = gpr_pkg::UNLOCK_W'(gpr_pkg::UNLOCK_CYCLES);
            end
        end
        if (wr && aligned && idx == gpr_pkg::ROUTE1_IDX && routing_write_unlock)
        begin
            next_pin_routing_1 = pwdata[gpr_pkg::ROUTE1_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_routing_0 <= '0;
            pin_routing_1 <= '0;
            drive_strength_select <= '0;
            unlock_cnt <= '0;
            rdata <= '0;
            hit <= 1'b0;
        end
        else
        begin
            pin_routing_0 <= next_pin_routing_0;
            pin_routing_1 <= next_pin_routing_1;
            drive_strength_select <= next_drive_strength_select;
            unlock_cnt <= next_unlock_cnt;
            rdata <= next_rdata;
            hit <= next_hit;
        end
    end

    assign high_drive = drive_strength_select;

    // Peripheral pin routing; overlapping claims on a pin are ORed
    assign t0a_sel = pin_routing_0[gpr_pkg::R0_T0A];
    assign t0a_both = t0a_sel & timer0_out_a_extra_select;
    always_comb
    begin
        alt_en = '0;
        alt_val = '0;
        // Timer1 B: F4 or B2
        if (pin_routing_0[gpr_pkg::R0_T1B])
        begin
            alt_en[gpr_pkg::PIN_F4] = periph_en[gpr_pkg::PF_T1B];
            alt_val[gpr_pkg::PIN_F4] = periph_out[gpr_pkg::PF_T1B];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_B2] = periph_en[gpr_pkg::PF_T1B];
            alt_val[gpr_pkg::PIN_B2] = periph_out[gpr_pkg::PF_T1B];
        end
        // Timer1 A: F5 or B1
        if (pin_routing_0[gpr_pkg::R0_T1A])
        begin
            alt_en[gpr_pkg::PIN_F5] = periph_en[gpr_pkg::PF_T1A];
            alt_val[gpr_pkg::PIN_F5] = periph_out[gpr_pkg::PF_T1A];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_B1] = periph_en[gpr_pkg::PF_T1A];
            alt_val[gpr_pkg::PIN_B1] = periph_out[gpr_pkg::PF_T1A];
        end
        // Timer0 B: F3 or D5
        if (pin_routing_0[gpr_pkg::R0_T0B])
        begin
            alt_en[gpr_pkg::PIN_F3] = periph_en[gpr_pkg::PF_T0B];
            alt_val[gpr_pkg::PIN_F3] = periph_out[gpr_pkg::PF_T0B];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_D5] = periph_en[gpr_pkg::PF_T0B];
            alt_val[gpr_pkg::PIN_D5] = periph_out[gpr_pkg::PF_T0B];
        end
        // Timer0 A: D6, E4, C0 or both E4 and C0
        if (!t0a_sel && !timer0_out_a_extra_select)
        begin
            alt_en[gpr_pkg::PIN_D6] = periph_en[gpr_pkg::PF_T0A];
            alt_val[gpr_pkg::PIN_D6] = periph_out[gpr_pkg::PF_T0A];
        end
        if (timer0_out_a_extra_select || t0a_both)
        begin
            alt_en[gpr_pkg::PIN_E4] = periph_en[gpr_pkg::PF_T0A];
            alt_val[gpr_pkg::PIN_E4] = periph_out[gpr_pkg::PF_T0A];
        end
        if (t0a_sel)
        begin
            alt_en[gpr_pkg::PIN_C0] = periph_en[gpr_pkg::PF_T0A];
            alt_val[gpr_pkg::PIN_C0] = periph_out[gpr_pkg::PF_T0A];
        end
        // SPI select: B1 or B2
        if (pin_routing_0[gpr_pkg::R0_SS])
        begin
            alt_en[gpr_pkg::PIN_B1] |= periph_en[gpr_pkg::PF_SS];
            alt_val[gpr_pkg::PIN_B1] |= periph_out[gpr_pkg::PF_SS];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_B2] |= periph_en[gpr_pkg::PF_SS];
            alt_val[gpr_pkg::PIN_B2] |= periph_out[gpr_pkg::PF_SS];
        end
        // Serial transmit: D6 or D1
        if (pin_routing_0[gpr_pkg::R0_TXD])
        begin
            alt_en[gpr_pkg::PIN_D6] |= periph_en[gpr_pkg::PF_TXD];
            alt_val[gpr_pkg::PIN_D6] |= periph_out[gpr_pkg::PF_TXD];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_D1] = periph_en[gpr_pkg::PF_TXD];
            alt_val[gpr_pkg::PIN_D1] = periph_out[gpr_pkg::PF_TXD];
        end
        // Timer2 B: F7 or D3
        if (pin_routing_1[gpr_pkg::R1_T2B])
        begin
            alt_en[gpr_pkg::PIN_F7] = periph_en[gpr_pkg::PF_T2B];
            alt_val[gpr_pkg::PIN_F7] = periph_out[gpr_pkg::PF_T2B];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_D3] = periph_en[gpr_pkg::PF_T2B];
            alt_val[gpr_pkg::PIN_D3] = periph_out[gpr_pkg::PF_T2B];
        end
        // Timer2 A: F6 or B3
        if (pin_routing_1[gpr_pkg::R1_T2A])
        begin
            alt_en[gpr_pkg::PIN_F6] = periph_en[gpr_pkg::PF_T2A];
            alt_val[gpr_pkg::PIN_F6] = periph_out[gpr_pkg::PF_T2A];
        end
        else
        begin
            alt_en[gpr_pkg::PIN_B3] = periph_en[gpr_pkg::PF_T2A];
            alt_val[gpr_pkg::PIN_B3] = periph_out[gpr_pkg::PF_T2A];
        end
        // Timer3 A: F1 unless sent to the comparator-input pin
        if (!pin_routing_1[gpr_pkg::R1_T3A])
        begin
            alt_en[gpr_pkg::PIN_F1] = periph_en[gpr_pkg::PF_T3A];
            alt_val[gpr_pkg::PIN_F1] = periph_out[gpr_pkg::PF_T3A];
        end
    end

    assign timer3_alt_out_en = pin_routing_1[gpr_pkg::R1_T3A] & periph_en[gpr_pkg::PF_T3A];
    assign timer3_alt_out = timer3_alt_out_en & periph_out[gpr_pkg::PF_T3A];
    // Receive taken from the synchronised level, never the raw pin
    assign serial_rxd = pin_routing_0[gpr_pkg::R0_RXD] ?
        level_all[gpr_pkg::PIN_D5] : level_all[gpr_pkg::PIN_D0];

    generate
        for (genvar p = 0; p < NP; p++)
        begin : g_port
            gpr_port #(.WIDTH(W)) u_port (
                .clk(clk),
                .reset_n(reset_n),
                .wr_latch(wr_latch[p]),
                .wr_dir(wr_dir[p]),
                .wr_toggle(wr_toggle[p]),
                .wdata(pwdata[W-1:0]),
                .alt_en(alt_en[p*W +: W]),
                .alt_val(alt_val[p*W +: W]),
                .pin_in(pin_in[p*W +: W]),
                .latch(latch_all[p*W +: W]),
                .dir(dir_all[p*W +: W]),
                .level(level_all[p*W +: W]),
                .pin_out(pin_out[p*W +: W]),
                .pin_oe(pin_oe[p*W +: W]),
                .pullup_en(pullup_en[p*W +: W])
            );
        end
    endgenerate

    a_route0_locked: assert property (@(posedge clk) disable iff (!reset_n)
        (!routing_write_unlock) |=> pin_routing_0 == $past(pin_routing_0))
        else $error("routing 0 changed while locked");
    a_route1_locked: assert property (@(posedge clk) disable iff (!reset_n)
        (!routing_write_unlock) |=> pin_routing_1 == $past(pin_routing_1))
        else $error("routing 1 changed while locked");
    a_unlock_window: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && aligned && idx == gpr_pkg::ROUTE0_IDX && !routing_write_unlock
            && pwdata[gpr_pkg::R0_UNLOCK])
        |=> routing_write_unlock [*6] ##1 !routing_write_unlock)
        else $error("unlock window is not six cycles");
    a_timer3_steer: assert property (@(posedge clk) disable iff (!reset_n)
        (pin_routing_1[gpr_pkg::R1_T3A] && periph_en[gpr_pkg::PF_T3A])
        |-> timer3_alt_out_en && !alt_en[gpr_pkg::PIN_F1])
        else $error("timer3 output A not steered to alternate pin");
    a_drive_bits: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && aligned && idx == gpr_pkg::DRIVE_IDX)
        |=> high_drive == $past(pwdata[gpr_pkg::DRIVE_W-1:0]))
        else $error("drive strength write lost");
    a_txd_route: assert property (@(posedge clk) disable iff (!reset_n)
        (!pin_routing_0[gpr_pkg::R0_TXD] && periph_en[gpr_pkg::PF_TXD])
        |-> alt_en[gpr_pkg::PIN_D1])
        else $error("serial transmit not on primary pin");

    c_unlocked_write: cover property (@(posedge clk) disable iff (!reset_n)
        routing_write_unlock && wr && idx == gpr_pkg::ROUTE1_IDX);
    c_toggle_write: cover property (@(posedge clk) disable iff (!reset_n) wr_toggle != '0);
    c_unmapped: cover property (@(posedge clk) disable iff (!reset_n) pslverr);
endmodule // gpr_top

// [tb/gpr_pin_model.sv]
// Pin model: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
module gpr_pin_model
(
    input wire logic clk,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pullup_en,
    input wire logic [39:0] ext_val,
    input wire logic [39:0] ext_en,
    output logic [39:0] pin_in
);
    // Floating pins flip each cycle so a stale value never passes
    logic [39:0] last = 40'h00_0000_0000;
    always_ff @(posedge clk)
        last <= pin_in;
    always_comb
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
            | (~pin_oe & ~ext_en & (pullup_en | ~last));
endmodule // gpr_pin_model

// [tb/gpr_top_tb_top.sv]
// Self-checking bench for the ports, drive select and pin routing
`timescale 1ns/1ps
module gpr_top_tb_top;
    typedef struct {
        logic [9:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
    } gpr_row_t;
    localparam logic [39:0] DIR_V = 40'h02_0F_00_00_F0;
    localparam logic [39:0] LAT_V = 40'h00_5A_00_33_CC;
    localparam logic [39:0] EXT_V = 40'h96_3C_01_5A_A5;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [39:0] pin_in, pin_out, pin_oe, pullup_en, ext_val, ext_en;
    logic [5:0] high_drive;
    logic [8:0] periph_out, periph_en;
    logic serial_rxd, t3_out, t3_en;
    int n_mismatch = 0;
    int num_checks = 0;
    gpr_row_t rows [10] = '{'{gpr_pkg::DIR_IDX[0], 8'hF0, 8'hF0},
        '{gpr_pkg::LATCH_IDX[0], 8'hCC, 8'hCC}, '{gpr_pkg::DIR_IDX[1], 8'h00, 8'h00},
        '{gpr_pkg::LATCH_IDX[1], 8'h33, 8'h33}, '{gpr_pkg::DIR_IDX[3], 8'h0F, 8'h0F},
        '{gpr_pkg::LATCH_IDX[3], 8'h5A, 8'h5A}, '{gpr_pkg::DIR_IDX[4], 8'h02, 8'h02},
        '{gpr_pkg::LATCH_IDX[4], 8'h00, 8'h00}, '{gpr_pkg::DRIVE_IDX, 8'hFF, 8'h3F},
        '{10'h00F, 8'hFF, 8'h00}};
    // Gap 4 lands one edge past the window, gap 3 on its last edge
    int wk [3] = '{4, 3, 0};
    gpr_row_t wins [3] = '{'{gpr_pkg::ROUTE1_IDX, 8'h03, 8'h00},
        '{gpr_pkg::ROUTE0_IDX, 8'h01, 8'h01}, '{gpr_pkg::ROUTE1_IDX, 8'h04, 8'h04}};

    gpr_top u_dut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_en(pullup_en), .high_drive(high_drive),
        .periph_out(periph_out), .periph_en(periph_en), .timer0_out_a_extra_select(1'b0),
        .serial_rxd(serial_rxd), .timer3_alt_out(t3_out), .timer3_alt_out_en(t3_en));
    gpr_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1)
            n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdck(input logic [9:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        chk({8'h00, rd}, {32'h0000_0000, exp});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        periph_out = 9'h000;
        periph_en = 9'h000;
        ext_en = 40'hFF_FFFF_FFFF;
        ext_val = EXT_V;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int p = 0; p < 5; p++)
        begin
            rdck(gpr_pkg::DIR_IDX[p], 8'h00);
            rdck(gpr_pkg::LATCH_IDX[p], 8'h00);
        end
        rdck(gpr_pkg::ROUTE0_IDX, 8'h00);
        rdck(gpr_pkg::ROUTE1_IDX, 8'h00);
        rdck(gpr_pkg::DRIVE_IDX, 8'h00);
        $display("test reset values done");
        foreach (rows[i])
        begin
            apb(rows[i].idx, 1'b1, rows[i].wd);
            rdck(rows[i].idx, rows[i].exp);
        end
        chk({39'h0, err}, 40'h1);
        $display("test register table done");
        @(negedge clk);
        chk(pin_oe, DIR_V);
        chk(pin_out, DIR_V & LAT_V);
        chk(pullup_en, ~DIR_V & LAT_V);
        chk({34'h0, high_drive}, 40'h3F);
        for (int p = 0; p < 5; p++)
            rdck(gpr_pkg::LEVEL_IDX[p], 8'(((DIR_V & LAT_V) | (~DIR_V & EXT_V)) >> (8 * p)));
        ext_val <= EXT_V ^ 40'h00_0000_FF00;
        rdck(gpr_pkg::LEVEL_IDX[1], 8'h5A);
        repeat (3) @(posedge clk);
        rdck(gpr_pkg::LEVEL_IDX[1], 8'hA5);
        apb(gpr_pkg::LEVEL_IDX[1], 1'b1, 8'h0F);
        rdck(gpr_pkg::LATCH_IDX[1], 8'h3C);
        apb(gpr_pkg::LEVEL_IDX[1], 1'b1, 8'h00);
        rdck(gpr_pkg::LATCH_IDX[1], 8'h3C);
        $display("test pins and levels done");
        periph_en <= 9'h140;
        periph_out <= 9'h140;
        @(negedge clk);
        chk({39'h0, pin_out[gpr_pkg::PIN_F1]}, 40'h1);
        chk({39'h0, serial_rxd}, 40'h1);
        foreach (wins[i])
        begin
            apb(gpr_pkg::ROUTE0_IDX, 1'b1, 8'h80);
            repeat (wk[i]) @(posedge clk);
            apb(wins[i].idx, 1'b1, wins[i].wd);
            repeat (6) @(posedge clk);
            rdck(wins[i].idx, wins[i].exp);
        end
        @(negedge clk);
        chk({38'h0, t3_en, t3_out}, 40'h3);
        chk({39'h0, pin_out[gpr_pkg::PIN_F1]}, 40'h0);
        chk({39'h0, serial_rxd}, 40'h0);
        $display("test routing done");
        @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        chk(pin_oe, 40'h00_0000_0000);
        chk({33'h0, t3_en, high_drive}, 40'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        rdck(gpr_pkg::ROUTE1_IDX, 8'h00);
        $display("test second reset done");
        print_verdict();
    end
endmodule // gpr_top_tb_top
